// ==== testbench/cmr_exec_sva.sv ====
// Port checks for the execution block
`timescale 1ns/100ps
`default_nettype none
module cmr_exec_sva (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       clk_en,
  input wire logic       op_valid,
  input wire logic [2:0] op_code,
  input wire logic       op_dest,
  input wire logic [7:0] file_rd_data,
  input wire logic       op_ready,
  input wire logic       file_wr_en,
  input wire logic [7:0] file_wr_data,
  input wire logic [7:0] working_reg,
  input wire logic       zero_flag,
  input wire logic       global_interrupt_enable_set
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  wire [15:0] g = {16{clk_en & op_valid & op_ready}} & 16'h0001 << {op_code, op_dest};
  wire [7:0] ow = working_reg | file_rd_data;
  wire z = working_reg == 8'h00;
  wire fz = file_rd_data == 8'h00;
  a_or_w: assert property (g[2] |=> working_reg == $past(ow) && zero_flag == z)
    else $error("or");
  a_or_f: assert property (g[3] |=> file_wr_en && file_wr_data == $past(ow))
    else $error("or file");
  a_cp_w: assert property (g[4] |=> working_reg == $past(file_rd_data))
    else $error("copy");
  a_cp_self: assert property (g[5] |=> $stable(working_reg) && zero_flag == $past(fz)
    && file_wr_en && file_wr_data == $past(file_rd_data))
    else $error("copy self");
  a_store_w: assert property (|g[7:6] |=> $stable(zero_flag) && file_wr_en
    && file_wr_data == $past(working_reg))
    else $error("store");
  a_lit_flags: assert property (|g[9:8] |=> $stable(zero_flag) && !file_wr_en)
    else $error("literal");
  a_ret_seq: assert property (|g[11:10] ##1 clk_en |-> !op_ready ##1 op_ready)
    else $error("return");
  a_ret_busy: assert property (|g[11:10] |=> !op_ready)
    else $error("return busy");
  a_ret_int_en: assert property (|g[11:10] |=> global_interrupt_enable_set)
    else $error("enable");
endmodule
bind cmr_exec cmr_exec_sva i_sva (.*);
`default_nettype wire

// ==== testbench/cmr_file_mdl.sv ====
// File register space model
`timescale 1ns/100ps
`default_nettype none
module cmr_file_mdl (
  input  wire logic       clk,
  input  wire logic [6:0] ra,
  input  wire logic       we,
  input  wire logic [6:0] wa,
  input  wire logic [7:0] wd,
  output logic      [7:0] rd
);
  logic [7:0] mem [128];
  initial
    for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37);
  assign rd = mem[ra];
  // No enable gate: a held write repeats harmlessly
  always @(posedge clk)
    if (we) mem[wa] <= wd;
endmodule
`default_nettype wire

// ==== testbench/cpu_move_or_return_ops_tb_top.sv ====
// Random instruction stream against a reference model
`timescale 1ns/100ps
`default_nettype none
module cpu_move_or_return_ops_tb_top;
  logic clk = 0, sys_rst = 1, clk_en = 0, op_valid = 0, op_dest = 0, z = 0, p = 0;
  logic [2:0] op_code = 3'h0;
  logic [6:0] op_addr = 7'h00;
  logic [7:0] op_literal = 8'h00, w = 8'h00, r, m [128];
  logic [12:0] top_of_stack = 13'h0000;
  wire op_ready, file_wr_en, zero_flag, stack_pop, pc_load, global_interrupt_enable_set;
  wire [6:0] file_addr, file_wr_addr;
  wire [7:0] file_rd_data, file_wr_data, working_reg;
  wire [12:0] pc_value;
  int error_cnt = 0, num_checks = 0;
  cmr_exec i_dut (.*);
  cmr_file_mdl i_mem (.clk, .ra(file_addr), .we(file_wr_en), .wa(file_wr_addr),
    .wd(file_wr_data), .rd(file_rd_data));
  task chk(string n, logic [12:0] s, e);
    num_checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", n, e, s);
    end
  endtask
  task tally_and_finish;
    if (error_cnt == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial forever #2.5 clk = ~clk;
  initial
  begin
    void'($urandom(32'h405230A4));
    for (int i = 0; i < 128; i++) m[i] = 8'(i * 37);
    repeat (16) @(negedge clk);
    sys_rst = 0;
    repeat (600)
    begin
      // Fresh address each time: writes land a cycle late
      {clk_en, op_valid, op_code, op_dest} = {$urandom % 8 != 0, 1'b1, 4'($urandom)};
      op_addr += 7'(1 + $urandom % 127);
      {op_literal, top_of_stack} = 21'($urandom);
      r = m[op_addr] | (op_code == 3'h1 ? w : 8'h00);
      @(negedge clk);
      if (clk_en && op_code inside {3'h1, 3'h2})
        {z, w, m[op_addr]} = {r == 8'h00, op_dest ? w : r, op_dest ? r : m[op_addr]};
      if (clk_en && op_code == 3'h3)
        m[op_addr] = w;
      if (clk_en && op_code == 3'h4)
        w = op_literal;
      if (clk_en)
        p = op_code == 3'h5;
      chk("w", working_reg, w);
      chk("z", zero_flag, z);
      chk("pop", stack_pop, p);
      chk("pcl", pc_load, p);
      chk("ien", global_interrupt_enable_set, p);
      if (clk_en && op_code == 3'h5)
      begin
        chk("pc", pc_value, top_of_stack);
        chk("busy", op_ready, 1'h0);
        // Second cycle, sometimes frozen by a low enable
        {op_valid, clk_en} = {1'h0, 1'($urandom)};
        @(negedge clk);
        chk("rdy", op_ready, clk_en);
        chk("held", stack_pop, !clk_en);
        clk_en = 1'h1;
        @(negedge clk);
        chk("idle", op_ready, 1'h1);
        p = 1'h0;
      end
    end
    {op_valid, clk_en} = 2'h1;
    @(negedge clk);
    for (int i = 0; i < 128; i++) chk("mem", i_mem.mem[i], m[i]);
    tally_and_finish;
  end
endmodule
`default_nettype wire

// ==== verilog/cmr_alu.v ====
// Result and zero flag for the OR and copy operations
`timescale 1ns/100ps
`default_nettype none
`include "cmr_defs.vh"
module cmr_alu #(
  parameter WIDTH = 8
) (
  input  wire [2:0]       op,
  input  wire [WIDTH-1:0] w_val,
  input  wire [WIDTH-1:0] file_val,
  output reg  [WIDTH-1:0] result,
  output wire             zero
);
  always @*
  begin
    if (op == `CMR_OP_OR_FILE)
      result = w_val | file_val;
    else
      result = file_val;
  end
  assign zero = (result == {WIDTH{1'h0}});
endmodule
`default_nettype wire

// ==== verilog/cmr_defs.vh ====
// Constants for the move, OR and return execution block
`ifndef CMR_DEFS_VH
`define CMR_DEFS_VH
`define CMR_OP_NONE      3'h0
`define CMR_OP_OR_FILE   3'h1
`define CMR_OP_COPY_FILE 3'h2
`define CMR_OP_STORE_W   3'h3
`define CMR_OP_LOAD_LIT  3'h4
`define CMR_OP_RET_INT   3'h5
`define CMR_INT_EN_BIT   7
`define CMR_DEST_W       1'h0
`define CMR_DEST_FILE    1'h1
`define CMR_ST_IDLE      1'h0
`define CMR_ST_RET2      1'h1
`define CMR_W_RESET      8'h00
`endif

// ==== verilog/cmr_exec.v ====
// Execution of OR, copy, store, literal load and return from interrupt
`timescale 1ns/100ps
`default_nettype none
`include "cmr_defs.vh"
module cmr_exec #(
  parameter WIDTH    = 8,
  parameter ADDR_W   = 7,
  parameter PC_W     = 13
) (
  input  wire              clk,
  input  wire              sys_rst,
  input  wire              clk_en,
  input  wire              op_valid,
  input  wire [2:0]        op_code,
  input  wire [ADDR_W-1:0] op_addr,
  input  wire              op_dest,
  input  wire [WIDTH-1:0]  op_literal,
  input  wire [WIDTH-1:0]  file_rd_data,
  input  wire [PC_W-1:0]   top_of_stack,
  output wire              op_ready,
  output wire [ADDR_W-1:0] file_addr,
  output reg               file_wr_en,
  output reg  [ADDR_W-1:0] file_wr_addr,
  output reg  [WIDTH-1:0]  file_wr_data,
  output reg  [WIDTH-1:0]  working_reg,
  output reg               zero_flag,
  output reg               stack_pop,
  output reg               pc_load,
  output reg  [PC_W-1:0]   pc_value,
  output reg               global_interrupt_enable_set
);
  reg              state;
  reg              take;
  wire [WIDTH-1:0] alu_result;
  wire             alu_zero;
  wire             do_or_file;
  wire             do_copy_file;
  wire             do_file_op;
  wire             to_file;
  wire             do_store;
  wire             do_load;
  wire             do_return;
  reg              next_state;
  reg              next_file_wr_en;
  reg [ADDR_W-1:0] next_file_wr_addr;
  reg [WIDTH-1:0]  next_file_wr_data;
  reg [WIDTH-1:0]  next_working_reg;
  reg              next_zero_flag;
  reg              next_stack_pop;
  reg              next_pc_load;
  reg [PC_W-1:0]   next_pc_value;
  reg              next_global_interrupt_enable_set;

  ////////////////////////////////////////////////////////////////////////////
  // Second cycle of return stalls new operations
  assign op_ready  = (state == `CMR_ST_IDLE);
  assign file_addr = op_addr;

  always @*
  begin
    take = op_valid & op_ready;
  end

  cmr_alu #(
    .WIDTH (WIDTH)
  ) u_alu (
    .op       (op_code),
    .w_val    (working_reg),
    .file_val (file_rd_data),
    .result   (alu_result),
    .zero     (alu_zero)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Opcodes decoded here, gated by take
  // Codes are this block's own; the fetch path maps the real encoding
  assign do_or_file   = take & (op_code == `CMR_OP_OR_FILE);
  assign do_copy_file = take & (op_code == `CMR_OP_COPY_FILE);
  assign do_file_op   = do_or_file | do_copy_file;
  assign to_file      = (op_dest == `CMR_DEST_FILE);
  assign do_store     = take & (op_code == `CMR_OP_STORE_W);
  assign do_load      = take & (op_code == `CMR_OP_LOAD_LIT);
  assign do_return    = take & (op_code == `CMR_OP_RET_INT);

  ////////////////////////////////////////////////////////////////////////////
  // Next values; pulses default low, anything else no operation moves holds
  always @*
  begin
    next_state                       = state;
    next_file_wr_en                  = 1'h0;
    next_file_wr_addr                = file_wr_addr;
    next_file_wr_data                = file_wr_data;
    next_working_reg                 = working_reg;
    next_zero_flag                   = zero_flag;
    next_stack_pop                   = 1'h0;
    next_pc_load                     = 1'h0;
    next_pc_value                    = pc_value;
    next_global_interrupt_enable_set = 1'h0;
    case (state)
      `CMR_ST_IDLE:
      begin
        if (do_file_op)
        begin
          next_zero_flag = alu_zero;
        end
        if (do_file_op && !to_file)
        begin
          next_working_reg = alu_result;
        end
        if (do_file_op && to_file)
        begin
          next_file_wr_en   = 1'h1;
          next_file_wr_addr = op_addr;
          next_file_wr_data = alu_result;
        end
        if (do_store)
        begin
          next_file_wr_en   = 1'h1;
          next_file_wr_addr = op_addr;
          next_file_wr_data = working_reg;
        end
        if (do_load)
        begin
          next_working_reg = op_literal;
        end
        if (do_return)
        begin
          next_stack_pop = 1'h1;
          next_pc_load   = 1'h1;
          next_pc_value  = top_of_stack;
          next_state     = `CMR_ST_RET2;
        end
        if (do_return)
        begin
          next_global_interrupt_enable_set = 1'h1;
        end
      end
      `CMR_ST_RET2:
      begin
        next_state = `CMR_ST_IDLE;
      end
      default:
      begin
        next_state = `CMR_ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      state <= `CMR_ST_IDLE;
    end
    else if (clk_en)
    begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // File write port; a pulse held by low enable only rewrites the same word
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      file_wr_en   <= 1'h0;
      file_wr_addr <= {ADDR_W{1'h0}};
      file_wr_data <= {WIDTH{1'h0}};
    end
    else if (clk_en)
    begin
      file_wr_en   <= next_file_wr_en;
      file_wr_addr <= next_file_wr_addr;
      file_wr_data <= next_file_wr_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Working register and zero flag
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      working_reg <= `CMR_W_RESET;
      zero_flag   <= 1'h0;
    end
    else if (clk_en)
    begin
      working_reg <= next_working_reg;
      zero_flag   <= next_zero_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Return pulses and program counter value
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      stack_pop                   <= 1'h0;
      pc_load                     <= 1'h0;
      pc_value                    <= {PC_W{1'h0}};
      global_interrupt_enable_set <= 1'h0;
    end
    else if (clk_en)
    begin
      stack_pop                   <= next_stack_pop;
      pc_load                     <= next_pc_load;
      pc_value                    <= next_pc_value;
      global_interrupt_enable_set <= next_global_interrupt_enable_set;
    end
  end
endmodule
`default_nettype wire
